// ### hw/dpwm_chan_if.sv
/*
 * dpwm_chan_if: settings into one modulator channel and its results.
 * Assumes: driven and read on the single bus clock.
 */
`timescale 1ns/1ps
interface dpwm_chan_if;
   logic [1:0] coarse_sel;
   logic [3:0] fine_div;
   logic [5:0] duty;
   logic pol;
   logic stop;
   logic wave;
   logic period_end;

   // register side
   modport regs (
      output coarse_sel,
      output fine_div,
      output duty,
      output pol,
      output stop,
      input wave,
      input period_end
   );

   // channel side
   modport chan (
      input coarse_sel,
      input fine_div,
      input duty,
      input pol,
      input stop,
      output wave,
      output period_end
   );
endinterface

// ### hw/dpwm_channel.sv
/*
 * dpwm_channel: two prescalers, 64-step modulus counter and waveform
 * flop of one modulator channel.
 * Assumes: settings arrive through dpwm_chan_if on the same clock.
 */
`timescale 1ns/1ps
module dpwm_channel (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // settings and results
   dpwm_chan_if.chan ch
);

   logic enabled;
   logic [3:0] coarse_cnt_r;
   logic [3:0] fine_cnt_r;
   logic [5:0] mod_cnt_r;
   logic wave_r;
   logic coarse_clock;
   logic scaled_clock;

   // ----------------------------------------------------------------
   // tick generation
   // ----------------------------------------------------------------
   assign enabled = (ch.coarse_sel != dpwm_pkg::COARSE_OFF);
   // coarse tick every 1, 8 or 16 bus clocks
   assign coarse_clock = enabled && !ch.stop &&
      (coarse_cnt_r == dpwm_pkg::coarse_limit(ch.coarse_sel));
   // fine tick every fine_div+1 coarse ticks
   assign scaled_clock = coarse_clock && (fine_cnt_r == ch.fine_div);
   assign ch.period_end = scaled_clock && (mod_cnt_r == dpwm_pkg::MOD_LAST);

   // coarse prescaler; held in stop, cleared when disabled
   always_ff @(posedge clk) begin
      if (reset || !enabled) begin
         coarse_cnt_r <= 4'h0;
      end else if (!ch.stop) begin
         coarse_cnt_r <= coarse_clock ? 4'h0 : coarse_cnt_r + 4'h1;
      end
   end

   // fine prescaler
   always_ff @(posedge clk) begin
      if (reset || !enabled) begin
         fine_cnt_r <= 4'h0;
      end else if (coarse_clock) begin
         fine_cnt_r <= scaled_clock ? 4'h0 : fine_cnt_r + 4'h1;
      end
   end

   // modulus counter, wraps after 64 scaled ticks
   always_ff @(posedge clk) begin
      if (reset || !enabled) begin
         mod_cnt_r <= 6'h00;
      end else if (scaled_clock) begin
         mod_cnt_r <= mod_cnt_r + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // waveform
   // ----------------------------------------------------------------
   // active while count below duty; lags the counter by one clock
   always_ff @(posedge clk) begin
      if (reset || !enabled) begin
         wave_r <= 1'b0;
      end else if (!ch.stop) begin
         wave_r <= ch.pol ? (mod_cnt_r < ch.duty) : !(mod_cnt_r < ch.duty);
      end
   end

   assign ch.wave = wave_r;

endmodule // dpwm_channel

// ### hw/dpwm_pkg.sv
/*
 * dpwm_pkg: register map, field layout, reset values and divider
 * constants of the dual pulse width modulator.
 * Assumes: nothing; used as dpwm_pkg::name by every design file except dpwm_chan_if.
 */
package dpwm_pkg;

   // ----------------------------------------------------------------
   // clock
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 200_000_000;

   // ----------------------------------------------------------------
   // register byte addresses (one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_CONTROL_A = 4'h0;
   localparam logic [3:0] OFS_CONTROL_B = 4'h4;
   localparam logic [3:0] OFS_DUTY_A = 4'h8;
   localparam logic [3:0] OFS_DUTY_B = 4'hc;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int FINE_LSB = 0;
   localparam int FINE_W = 4;
   localparam int COARSE_LSB = 4;
   localparam int COARSE_W = 2;
   localparam int CTRL_W = 6;
   localparam logic [5:0] CONTROL_RST = 6'h00;

   // ----------------------------------------------------------------
   // duty register fields
   // ----------------------------------------------------------------
   localparam int DUTY_LSB = 0;
   localparam int DUTY_W = 6;
   localparam int POL_BIT = 7;

   // ----------------------------------------------------------------
   // divider and modulus constants
   // ----------------------------------------------------------------
   localparam logic [1:0] COARSE_OFF = 2'h0;
   localparam logic [1:0] COARSE_DIV1 = 2'h1;
   localparam logic [1:0] COARSE_DIV8 = 2'h2;
   localparam logic [1:0] COARSE_DIV16 = 2'h3;
   localparam logic [3:0] COARSE_LIM1 = 4'h0;
   localparam logic [3:0] COARSE_LIM8 = 4'h7;
   localparam logic [3:0] COARSE_LIM16 = 4'hf;
   localparam logic [5:0] MOD_LAST = 6'h3f;

   // terminal count of the coarse prescaler for a select value
   function automatic logic [3:0] coarse_limit(input logic [1:0] sel);
      case (sel)
         COARSE_DIV8: coarse_limit = COARSE_LIM8;
         COARSE_DIV16: coarse_limit = COARSE_LIM16;
         default: coarse_limit = COARSE_LIM1;
      endcase
   endfunction

endpackage

// ### hw/dpwm_top.sv
/*
 * dpwm_top: dual pulse width modulator with Avalon-MM register slave,
 * buffered duty registers and port pin hand-over.
 * Assumes: one 200 MHz bus clock, synchronous active-high reset,
 * wait_mode, stop_mode and port data/direction from same-clock logic.
 */
//
// How it works
// - duty zero low; maximum gives 63/64
// - polarity zero with duty zero stays high
// - coarse field 00 stops channel
// - control writes act at once
// - enabled duty writes wait for period end
// - disabled duty writes load immediately
// - buffered values applied together at period end
// - duty read returns active value
// - channel A polarity one means active high
// - channel B polarity behaves like A
// - coarse field divides by 1, 8, 16
// - fine field divides by value plus one
// - six-bit duty per channel
// - enabled channel owns its port pin
// - channel B control mirrors A
// - duty bits survive reset
// - reset disables channels, outputs low
// - wait mode keeps running
// - stop mode freezes waveform mid-phase
// - period spans 64 scaled ticks
// - input clock is bus clock
//
`timescale 1ns/1ps
module dpwm_top (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // avalon-mm register slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // power modes
   input wire logic wait_mode,
   input wire logic stop_mode,
   // ordinary port control of the two shared pins
   input wire logic port_data_four,
   input wire logic port_dir_four,
   input wire logic port_data_five,
   input wire logic port_dir_five,
   // shared pins
   output logic port_pin_four_o,
   output logic port_pin_four_oe,
   output logic port_pin_five_o,
   output logic port_pin_five_oe,
   // raw modulator waveforms
   output logic modulator_out_a,
   output logic modulator_out_b
);

   localparam int NCH = 2;

   // ----------------------------------------------------------------
   // field helpers
   // ----------------------------------------------------------------
   // coarse select field of a control word
   function automatic logic [dpwm_pkg::COARSE_W-1:0] coarse_of(
      input logic [dpwm_pkg::CTRL_W-1:0] ctrl
   );
      coarse_of = ctrl[dpwm_pkg::COARSE_LSB +: dpwm_pkg::COARSE_W];
   endfunction

   // fine divide field of a control word
   function automatic logic [dpwm_pkg::FINE_W-1:0] fine_of(
      input logic [dpwm_pkg::CTRL_W-1:0] ctrl
   );
      fine_of = ctrl[dpwm_pkg::FINE_LSB +: dpwm_pkg::FINE_W];
   endfunction

   // control word as software reads it, upper bits zero
   function automatic logic [31:0] control_image(
      input logic [dpwm_pkg::CTRL_W-1:0] ctrl
   );
      control_image = 32'h00000000;
      control_image[dpwm_pkg::CTRL_W-1:0] = ctrl;
   endfunction

   // duty word as software reads it: active duty plus polarity
   function automatic logic [31:0] duty_image(
      input logic [dpwm_pkg::DUTY_W-1:0] duty,
      input logic pol
   );
      duty_image = 32'h00000000;
      duty_image[dpwm_pkg::DUTY_LSB +: dpwm_pkg::DUTY_W] = duty;
      duty_image[dpwm_pkg::POL_BIT] = pol;
   endfunction

   // pin level: the wave while the channel owns the pin, else port data
   function automatic logic pin_level(
      input logic owned,
      input logic wave_in,
      input logic data_in
   );
      pin_level = owned ? wave_in : data_in;
   endfunction

   // pin enable: forced on while the channel owns the pin
   function automatic logic pin_enable(
      input logic owned,
      input logic dir_in
   );
      pin_enable = owned ? 1'b1 : dir_in;
   endfunction

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   logic ack_r;
   logic req;
   logic wr_take;
   logic rd_capture;
   logic [31:0] readdata_r;
   logic [31:0] rd_mux;

   // every request waits exactly one clock, then completes
   assign req = read || write;
   assign waitrequest = req && !ack_r;
   assign wr_take = write && ack_r && byteenable[0];
   // read data is latched in the wait cycle, while the address stands
   assign rd_capture = read && !ack_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req && !ack_r;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   logic [dpwm_pkg::CTRL_W-1:0] control_r [NCH];
   logic [NCH-1:0] ctrl_wr;
   logic [NCH-1:0] duty_wr;
   logic [NCH-1:0] enabled;
   logic [dpwm_pkg::CTRL_W-1:0] wr_ctrl;
   logic [dpwm_pkg::DUTY_W-1:0] wr_duty;
   logic wr_pol;

   // fields of the incoming byte, shared by every register write
   assign wr_ctrl = writedata[dpwm_pkg::CTRL_W-1:0];
   assign wr_duty = writedata[dpwm_pkg::DUTY_LSB +: dpwm_pkg::DUTY_W];
   assign wr_pol = writedata[dpwm_pkg::POL_BIT];

   // one strobe per register, raised only on the completing edge
   assign ctrl_wr[0] = wr_take && (address == dpwm_pkg::OFS_CONTROL_A);
   assign ctrl_wr[1] = wr_take && (address == dpwm_pkg::OFS_CONTROL_B);
   assign duty_wr[0] = wr_take && (address == dpwm_pkg::OFS_DUTY_A);
   assign duty_wr[1] = wr_take && (address == dpwm_pkg::OFS_DUTY_B);

   // control takes effect on the accepting edge, no period wait
   always_ff @(posedge clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (reset) begin
            control_r[i] <= dpwm_pkg::CONTROL_RST;
         end else if (ctrl_wr[i]) begin
            control_r[i] <= wr_ctrl;
         end
      end
   end

   // a channel runs whenever its coarse select is non-zero
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         enabled[i] = (coarse_of(control_r[i]) != dpwm_pkg::COARSE_OFF);
      end
   end

   // ----------------------------------------------------------------
   // duty registers: active copy plus holding buffer
   // ----------------------------------------------------------------
   logic [dpwm_pkg::DUTY_W-1:0] duty_active_r [NCH];
   logic [dpwm_pkg::DUTY_W-1:0] duty_buf_r [NCH];
   logic pol_active_r [NCH];
   logic pol_buf_r [NCH];
   logic [NCH-1:0] pend_r;
   logic [NCH-1:0] period_end;
   logic [NCH-1:0] wave;

   logic [NCH-1:0] load_now;
   logic [NCH-1:0] load_buf;

   // a write to an idle channel lands at once, else at the period end;
   // copying only at the period end keeps a running waveform whole
   assign load_now = duty_wr & ~enabled;
   assign load_buf = period_end & pend_r & ~load_now;

   // active duty; no reset, so the data bits keep their value
   always_ff @(posedge clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (load_now[i]) begin
            duty_active_r[i] <= wr_duty;
         end else if (load_buf[i]) begin
            duty_active_r[i] <= duty_buf_r[i];
         end
      end
   end

   // active polarity moves with the duty, never on its own
   always_ff @(posedge clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (load_now[i]) begin
            pol_active_r[i] <= wr_pol;
         end else if (load_buf[i]) begin
            pol_active_r[i] <= pol_buf_r[i];
         end
      end
   end

   // holding duty fills on every write to a running channel
   always_ff @(posedge clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (duty_wr[i] && enabled[i]) begin
            duty_buf_r[i] <= wr_duty;
         end
      end
   end

   // holding polarity, written together with the holding duty
   always_ff @(posedge clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (duty_wr[i] && enabled[i]) begin
            pol_buf_r[i] <= wr_pol;
         end
      end
   end

   // pending flag: a new write wins over the period-end clear
   always_ff @(posedge clk) begin
      for (int i = 0; i < NCH; i++) begin
         if (reset) begin
            pend_r[i] <= 1'b0;
         end else if (duty_wr[i]) begin
            pend_r[i] <= enabled[i];
         end else if (period_end[i]) begin
            pend_r[i] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   dpwm_chan_if chan_a ();
   dpwm_chan_if chan_b ();

   // wait mode needs no gating: a channel keeps running until software
   // clears its coarse select, the only way to save its power.
   // stop freezes both channels in whatever phase they happen to be in;
   // nothing is cleared, so each waveform resumes where it stopped.
   logic freeze;

   assign freeze = stop_mode;
   assign chan_a.coarse_sel = coarse_of(control_r[0]);
   assign chan_a.fine_div = fine_of(control_r[0]);
   assign chan_a.duty = duty_active_r[0];
   assign chan_a.pol = pol_active_r[0];
   assign chan_a.stop = freeze;
   assign chan_b.coarse_sel = coarse_of(control_r[1]);
   assign chan_b.fine_div = fine_of(control_r[1]);
   assign chan_b.duty = duty_active_r[1];
   assign chan_b.pol = pol_active_r[1];
   assign chan_b.stop = freeze;

   assign period_end[0] = chan_a.period_end;
   assign period_end[1] = chan_b.period_end;
   assign wave[0] = chan_a.wave;
   assign wave[1] = chan_b.wave;

   dpwm_channel u_chan_a (
      .clk(clk),
      .reset(reset),
      .ch(chan_a)
   );

   dpwm_channel u_chan_b (
      .clk(clk),
      .reset(reset),
      .ch(chan_b)
   );

   // ----------------------------------------------------------------
   // pin hand-over
   // ----------------------------------------------------------------
   // enabled channel drives its pin; otherwise ordinary port control
   // a disabled channel leaves level and direction to the port logic
   assign port_pin_four_o = pin_level(enabled[0], wave[0], port_data_four);
   assign port_pin_four_oe = pin_enable(enabled[0], port_dir_four);
   assign port_pin_five_o = pin_level(enabled[1], wave[1], port_data_five);
   assign port_pin_five_oe = pin_enable(enabled[1], port_dir_five);
   assign modulator_out_a = wave[0];
   assign modulator_out_b = wave[1];

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // duty reads show the active copy, never the buffer
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (address)
         dpwm_pkg::OFS_CONTROL_A: rd_mux = control_image(control_r[0]);
         dpwm_pkg::OFS_CONTROL_B: rd_mux = control_image(control_r[1]);
         dpwm_pkg::OFS_DUTY_A: rd_mux = duty_image(duty_active_r[0], pol_active_r[0]);
         dpwm_pkg::OFS_DUTY_B: rd_mux = duty_image(duty_active_r[1], pol_active_r[1]);
         default: rd_mux = 32'h00000000; // unmapped reads zero
      endcase
   end

   // captured in the wait cycle so data stands at the completing edge
   always_ff @(posedge clk) begin
      if (reset) begin
         readdata_r <= 32'h00000000;
      end else if (rd_capture) begin
         readdata_r <= rd_mux;
      end
   end

   assign readdata = readdata_r;

endmodule // dpwm_top

// ### verif/dpwm_load.sv
/* dpwm_load: external load on one shared pin, counting high cycles.
   Assumes: bench clock; the pin is pulled down while released. */
`timescale 1ns/1ps
module dpwm_load (
   // clock and count control
   input wire logic clk,
   input wire logic clr,
   // pin from the modulator
   input wire logic pin_o,
   input wire logic pin_oe,
   // resolved level and count
   output logic level,
   output logic [11:0] highs
);
   // released pin falls to the pull-down, never the last driven value
   assign level = pin_oe ? pin_o : 1'b0;
   // high cycles since the last clear
   always_ff @(posedge clk) begin
      if (clr) begin
         highs <= 12'h000;
      end else begin
         highs <= highs + {11'h000, level};
      end
   end
endmodule // dpwm_load

// ### verif/dpwm_top_monitor.sv
/* dpwm_monitor: port-level assertions of the dual modulator.
   Assumes: bound into dpwm_top; one clock, sync active-high reset. */
`timescale 1ns/1ps
module dpwm_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register bus
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // modes and pins
   input wire logic stop_mode,
   input wire logic port_data_four,
   input wire logic port_dir_four,
   input wire logic port_pin_four_o,
   input wire logic port_pin_four_oe,
   input wire logic port_pin_five_oe,
   input wire logic modulator_out_a,
   input wire logic modulator_out_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic wr_done;
   // a write lands at the edge where waitrequest is low
   assign wr_done = write && !waitrequest && byteenable[0];
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_one_wait;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus answer late");
   property p_idle;
      !(read || write) |-> !waitrequest;
   endproperty
   a_idle: assert property (p_idle) else $error("wait without request");
   property p_upper;
      read && !waitrequest |-> readdata[31:8] == 24'h000000;
   endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_off_a;
      wr_done && address == dpwm_pkg::OFS_CONTROL_A && writedata[5:4] == 2'h0 |=>
         port_pin_four_oe == port_dir_four && port_pin_four_o == port_data_four
         ##1 !modulator_out_a;
   endproperty
   a_off_a: assert property (p_off_a) else $error("channel a not off");
   property p_on_b;
      wr_done && address == dpwm_pkg::OFS_CONTROL_B && writedata[5:4] != 2'h0 |=>
         port_pin_five_oe;
   endproperty
   a_on_b: assert property (p_on_b) else $error("pin five not taken");
   property p_pin_a;
      !port_dir_four && port_pin_four_oe |-> port_pin_four_o == modulator_out_a;
   endproperty
   a_pin_a: assert property (p_pin_a) else $error("pin four not wave");
   property p_rst;
      $past(reset) |-> !modulator_out_a && !modulator_out_b;
   endproperty
   a_rst: assert property (p_rst) else $error("output high after reset");
   property p_stop_a;
      $past(stop_mode) && !$past(write) && !$past(reset) |-> $stable(modulator_out_a);
   endproperty
   a_stop_a: assert property (p_stop_a) else $error("a moved in stop");
   property p_stop_b;
      $past(stop_mode) && !$past(write) && !$past(reset) |-> $stable(modulator_out_b);
   endproperty
   a_stop_b: assert property (p_stop_b) else $error("b moved in stop");
   // main scenarios reached
   c_wr: cover property (wr_done);
   c_stop: cover property (stop_mode && modulator_out_b);
   c_rise_b: cover property ($rose(modulator_out_b));
endmodule // dpwm_monitor
bind dpwm_top dpwm_monitor dpwm_monitor_inst (.clk, .reset, .address, .read, .write,
   .writedata, .byteenable, .readdata, .waitrequest, .stop_mode, .port_data_four,
   .port_dir_four, .port_pin_four_o, .port_pin_four_oe, .port_pin_five_oe,
   .modulator_out_a, .modulator_out_b);

// ### verif/dual_pulse_width_modulator_bench.sv
/* dual_pulse_width_modulator_bench: register and waveform tests.
   Assumes: dpwm_top, dpwm_load and the bound monitor are compiled. */
`timescale 1ns/1ps
module dual_pulse_width_modulator_bench;
   logic clk, reset, read, write, wait_mode, stop_mode, clr, pd4, pdir4;
   logic [3:0] address, be;
   logic [31:0] writedata, readdata, q;
   logic waitrequest, o4, oe4, o5, oe5, out_a, out_b, lv_a, lv_b;
   logic [11:0] hi_a, hi_b;
   logic [7:0] duty_v [4] = '{8'h80, 8'hbf, 8'h00, 8'h10};
   logic [31:0] hi_v [4] = '{32'd0, 32'd63, 32'd64, 32'd48};
   logic [7:0] ctl_v [3] = '{8'h20, 8'h31, 8'h13};
   int per_v [3] = '{512, 2048, 256};
   int err_total = 0;
   int cmp_count = 0;
   int n;
   dpwm_top dpwm_top_inst (.clk(clk), .reset(reset), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(be), .readdata(readdata),
      .waitrequest(waitrequest), .wait_mode(wait_mode), .stop_mode(stop_mode),
      .port_data_four(pd4), .port_dir_four(pdir4), .port_data_five(1'b0),
      .port_dir_five(1'b0), .port_pin_four_o(o4), .port_pin_four_oe(oe4),
      .port_pin_five_o(o5), .port_pin_five_oe(oe5), .modulator_out_a(out_a),
      .modulator_out_b(out_b));
   dpwm_load dpwm_load_inst (.clk(clk), .clr(clr), .pin_o(o4), .pin_oe(oe4), .level(lv_a),
      .highs(hi_a));
   dpwm_load dpwm_load_inst_b (.clk(clk), .clr(clr), .pin_o(o5), .pin_oe(oe5),
      .level(lv_b), .highs(hi_b));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one bus cycle; held until waitrequest is seen low at a rising edge
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= {24'h000000, d};
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (waitrequest !== 1'b0 && i < 20);
      if (waitrequest !== 1'b0) begin
         chk({31'h0, waitrequest}, 32'h0);
         stop_test();
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      acc(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   // count pin high cycles over a window of cyc cycles
   task automatic meas(input int cyc, input logic [31:0] ea, input logic [31:0] eb);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (cyc) @(posedge clk);
      @(negedge clk);
      chk({20'h0, hi_a}, ea);
      chk({20'h0, hi_b}, eb);
   endtask
   // ----------------------------------------------------------------
   // clock and sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      {read, write, wait_mode, stop_mode, clr, pdir4} = 6'h00;
      pd4 = 1'b1;
      address = 4'h0;
      be = 4'h1;
      writedata = 32'h0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rd(dpwm_pkg::OFS_CONTROL_A, 32'h0);
      acc(1'b1, 4'h2, 8'h3f);
      rd(4'h2, 32'h0);
      // a write without its low byte lane is ignored
      be <= 4'h0;
      acc(1'b1, dpwm_pkg::OFS_CONTROL_B, 8'h30);
      be <= 4'h1;
      rd(dpwm_pkg::OFS_CONTROL_B, 32'h0);
      acc(1'b1, dpwm_pkg::OFS_DUTY_A, 8'h90);
      rd(dpwm_pkg::OFS_DUTY_A, 32'h90);
      acc(1'b1, dpwm_pkg::OFS_CONTROL_A, 8'h10);
      meas(64, 32'd16, 32'd0);
      chk({31'h0, oe4}, 32'h1);
      // park just after the active part so the write sits mid-period
      for (n = 0; n < 200 && out_a !== 1'b1; n++) @(negedge clk);
      chk({31'h0, out_a}, 32'h1);
      for (n = 0; n < 200 && out_a !== 1'b0; n++) @(negedge clk);
      chk({31'h0, out_a}, 32'h0);
      if (err_total != 0) begin
         stop_test();
      end
      acc(1'b1, dpwm_pkg::OFS_DUTY_A, 8'hb0);
      rd(dpwm_pkg::OFS_DUTY_A, 32'h90);
      repeat (64) @(posedge clk);
      rd(dpwm_pkg::OFS_DUTY_A, 32'hb0);
      wait_mode <= 1'b1;
      foreach (duty_v[k]) begin
         acc(1'b1, dpwm_pkg::OFS_DUTY_A, duty_v[k]);
         repeat (140) @(posedge clk);
         meas(64, hi_v[k], 32'd0);
      end
      acc(1'b1, dpwm_pkg::OFS_DUTY_B, 8'h88);
      foreach (ctl_v[k]) begin
         acc(1'b1, dpwm_pkg::OFS_CONTROL_B, ctl_v[k]);
         repeat (per_v[k] + 64) @(posedge clk);
         meas(per_v[k], per_v[k] * 3 / 4, per_v[k] / 8);
      end
      @(posedge clk);
      stop_mode <= 1'b1;
      @(negedge clk);
      q = {30'h0, out_a, out_b};
      repeat (40) @(negedge clk);
      chk({30'h0, out_a, out_b}, q);
      @(posedge clk);
      stop_mode <= 1'b0;
      pdir4 <= 1'b1;
      pd4 <= 1'b0;
      acc(1'b1, dpwm_pkg::OFS_CONTROL_A, 8'h00);
      @(negedge clk);
      chk({30'h0, oe4, o4}, {30'h0, pdir4, pd4});
      repeat (2) @(negedge clk);
      chk({31'h0, out_a}, 32'h0);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(dpwm_pkg::OFS_DUTY_A, 32'h10);
      rd(dpwm_pkg::OFS_CONTROL_B, 32'h0);
      chk({31'h0, out_b}, 32'h0);
      stop_test();
   end
endmodule // dual_pulse_width_modulator_bench
